// ===== sbrp_pkg.sv
/*
 Constants for the serial bus byte request port: register offsets, field
 positions, reset values, sequencing codes and bus timing.
 Assumes a 125 MHz core clock and byte-wide configuration access.
*/
`default_nettype none
package sbrp_pkg;
    localparam logic [7:0] OFS_DATA   = 8'hB0;
    localparam logic [7:0] OFS_INDEX  = 8'hB1;
    localparam logic [7:0] OFS_TARGET = 8'hB2;
    localparam logic [7:0] OFS_CTRL   = 8'hB3;
    localparam logic [7:0] RST_BYTE   = 8'h00;

    localparam int CTL_PROT_BIT = 7;
    localparam int CTL_BUSY_BIT = 5;
    localparam int CTL_FAST_BIT = 2;
    localparam int CTL_ERR_BIT  = 1;
    localparam int DIR_BIT      = 0;

    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [1:0] {
        SBRP_CMD_START = 2'h0,
        SBRP_CMD_STOP  = 2'h1,
        SBRP_CMD_WRITE = 2'h2,
        SBRP_CMD_READ  = 2'h3
    } sbrp_cmd_t;

    typedef enum logic [1:0] {
        SBRP_STEP_ADDR  = 2'h0,
        SBRP_STEP_INDEX = 2'h1,
        SBRP_STEP_DATA  = 2'h2,
        SBRP_STEP_RADDR = 2'h3
    } sbrp_step_t;

    localparam int CLK_NS      = 8;
    localparam int QTR_NS      = 2500;
    localparam int QTR_FAST_NS = 625;
    localparam int QTR_CYC      = (QTR_NS / CLK_NS) < 1 ? 1 : QTR_NS / CLK_NS;
    localparam int QTR_FAST_CYC = (QTR_FAST_NS / CLK_NS) < 1 ? 1 : QTR_FAST_NS / CLK_NS;
endpackage
`default_nettype wire

// ===== sbrp_bit_if.sv
/*
 Carrier between the byte sequencer and the bit engine.
 Assumes both ends run on the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface sbrp_bit_if;
    sbrp_pkg::sbrp_cmd_t cmd;
    logic                cmd_valid;
    logic                wbit;
    logic                fast;
    logic                ready;
    logic                done;
    logic                rbit;
    logic                scl_oe;
    logic                sda_oe;

    modport eng (input cmd, input cmd_valid, input wbit, input fast,
                 output ready, output done, output rbit, output scl_oe, output sda_oe);
    modport seq (output cmd, output cmd_valid, output wbit, output fast,
                 input ready, input done, input rbit, input scl_oe, input sda_oe);
endinterface
`default_nettype wire

// ===== sbrp_bit_eng.sv
/*
 Bit engine: one start, stop, write bit or read bit per command, in four
 quarter periods of the serial clock, with target clock stretching.
 Assumes open-drain pins; pin inputs arrive unsynchronised.
*/
`timescale 1ns/1ns
`default_nettype none
module sbrp_bit_eng #(
    parameter int QTR_CYC      = sbrp_pkg::QTR_CYC,
    parameter int QTR_FAST_CYC = sbrp_pkg::QTR_FAST_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic scl_i,
    input  wire logic sda_i,
    sbrp_bit_if.eng   bus
);
    typedef enum logic [1:0] {
        SBRP_E_IDLE = 2'b01,
        SBRP_E_RUN  = 2'b10
    } sbrp_est_t;

    // Returns {scl released, sda released} for a quarter of a command
    function automatic logic [1:0] drive(input sbrp_pkg::sbrp_cmd_t c, input logic [1:0] q, input logic b);
        logic [1:0] r;
        r = 2'h3;
        case (c)
            sbrp_pkg::SBRP_CMD_START: r = (q == 2'h0) ? 2'h1 : (q == 2'h1) ? 2'h3 : (q == 2'h2) ? 2'h2 : 2'h0;
            sbrp_pkg::SBRP_CMD_STOP:  r = (q == 2'h0) ? 2'h0 : (q == 2'h1) ? 2'h2 : 2'h3;
            default:                  r = {(q == 2'h1) || (q == 2'h2), b};
        endcase
        return r;
    endfunction

    sbrp_est_t           st_ff, nxt_st;
    sbrp_pkg::sbrp_cmd_t cmd_ff, nxt_cmd;
    logic                wbit_ff, nxt_wbit;
    logic [1:0]          q_ff, nxt_q;
    logic [15:0]         cnt_ff, nxt_cnt;
    logic                scl_oe_ff, nxt_scl_oe;
    logic                sda_oe_ff, nxt_sda_oe;
    logic                rbit_ff, nxt_rbit;
    logic                done_ff, nxt_done;
    logic [1:0]          scl_sync_ff;
    logic [1:0]          sda_sync_ff;
    logic [1:0]          rel;
    logic [15:0]         qlen;

    assign qlen       = bus.fast ? 16'(QTR_FAST_CYC - 1) : 16'(QTR_CYC - 1);
    assign bus.ready  = (st_ff == SBRP_E_IDLE) && !done_ff;
    assign bus.done   = done_ff;
    assign bus.rbit   = rbit_ff;
    assign bus.scl_oe = scl_oe_ff;
    assign bus.sda_oe = sda_oe_ff;

    always_comb begin
        nxt_st     = st_ff;
        nxt_cmd    = cmd_ff;
        nxt_wbit   = wbit_ff;
        nxt_q      = q_ff;
        nxt_cnt    = cnt_ff;
        nxt_rbit   = rbit_ff;
        nxt_done   = 1'b0;
        nxt_scl_oe = scl_oe_ff;
        nxt_sda_oe = sda_oe_ff;
        rel        = drive(cmd_ff, q_ff, wbit_ff);
        case (st_ff)
            SBRP_E_IDLE: begin
                if (bus.cmd_valid && !done_ff) begin
                    nxt_st   = SBRP_E_RUN;
                    nxt_cmd  = bus.cmd;
                    nxt_wbit = (bus.cmd == sbrp_pkg::SBRP_CMD_READ) ? 1'b1 : bus.wbit;
                    nxt_q    = 2'h0;
                    nxt_cnt  = 16'h0000;
                end
            end
            SBRP_E_RUN: begin
                nxt_scl_oe = !rel[1];
                nxt_sda_oe = !rel[0];
                // Hold the quarter while a target stretches the clock low
                if (!(rel[1] && !scl_sync_ff[1])) begin
                    if (cnt_ff >= qlen) begin
                        nxt_cnt = 16'h0000;
                        if (q_ff == 2'h2) begin
                            nxt_rbit = sda_sync_ff[1];
                        end
                        if (q_ff == 2'h3) begin
                            nxt_st   = SBRP_E_IDLE;
                            nxt_done = 1'b1;
                        end else begin
                            nxt_q = q_ff + 2'h1;
                        end
                    end else begin
                        nxt_cnt = cnt_ff + 16'h0001;
                    end
                end
            end
            default: nxt_st = SBRP_E_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff       <= SBRP_E_IDLE;
            cmd_ff      <= sbrp_pkg::SBRP_CMD_START;
            wbit_ff     <= 1'b1;
            q_ff        <= 2'h0;
            cnt_ff      <= 16'h0000;
            scl_oe_ff   <= 1'b0;
            sda_oe_ff   <= 1'b0;
            rbit_ff     <= 1'b1;
            done_ff     <= 1'b0;
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
        end else begin
            st_ff       <= nxt_st;
            cmd_ff      <= nxt_cmd;
            wbit_ff     <= nxt_wbit;
            q_ff        <= nxt_q;
            cnt_ff      <= nxt_cnt;
            scl_oe_ff   <= nxt_scl_oe;
            sda_oe_ff   <= nxt_sda_oe;
            rbit_ff     <= nxt_rbit;
            done_ff     <= nxt_done;
            scl_sync_ff <= {scl_sync_ff[0], scl_i};
            sda_sync_ff <= {sda_sync_ff[0], sda_i};
        end
    end
endmodule
`default_nettype wire

// ===== sbrp_top.sv
/*
 Serial bus byte request port: byte-wide configuration registers and a
 byte sequencer that runs one requested read or write on the two-wire bus.
 Assumes a byte configuration port on the core clock and open-drain pins.
*/
`timescale 1ns/1ns
`default_nettype none
module sbrp_top #(
    parameter int QTR_CYC      = sbrp_pkg::QTR_CYC,
    parameter int QTR_FAST_CYC = sbrp_pkg::QTR_FAST_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       cfg_wr_en,
    input  wire logic [7:0] cfg_addr,
    input  wire logic [7:0] cfg_wdata,
    output logic      [7:0] cfg_rdata,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe
);
    typedef enum logic [4:0] {
        SBRP_S_IDLE  = 5'b00001,
        SBRP_S_START = 5'b00010,
        SBRP_S_SEND  = 5'b00100,
        SBRP_S_RECV  = 5'b01000,
        SBRP_S_STOP  = 5'b10000
    } sbrp_state_t;

    sbrp_bit_if bit_bus ();

    logic [1:0]           rst_sync_ff;
    logic                 rst_n;
    sbrp_state_t          st_ff, nxt_st;
    sbrp_pkg::sbrp_step_t step_ff, nxt_step;
    logic [7:0]           data_ff, nxt_data;
    logic [7:0]           index_ff, nxt_index;
    logic [7:0]           target_ff, nxt_target;
    logic                 prot_ff, nxt_prot;
    logic                 fast_ff, nxt_fast;
    logic                 err_ff, nxt_err;
    logic                 busy_ff, nxt_busy;
    logic [7:0]           shift_ff, nxt_shift;
    logic [3:0]           bit_ff, nxt_bit;
    logic                 pend_ff, nxt_pend;
    logic [7:0]           rdata_ff, nxt_rdata;
    logic                 wr_data, wr_index, wr_target, wr_ctrl;
    logic                 read_dir;

    sbrp_bit_eng #(
        .QTR_CYC      (QTR_CYC),
        .QTR_FAST_CYC (QTR_FAST_CYC)
    ) u_eng (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .scl_i    (scl_i),
        .sda_i    (sda_i),
        .bus      (bit_bus.eng)
    );

    // Open drain: the pins only ever pull low
    assign scl_o     = 1'b0;
    assign sda_o     = 1'b0;
    assign scl_oe    = bit_bus.scl_oe;
    assign sda_oe    = bit_bus.sda_oe;
    assign cfg_rdata = rdata_ff;
    assign rst_n     = rst_sync_ff[1];

    // Data, index and target are locked while a transfer runs so it sees stable values
    assign wr_data   = cfg_wr_en && (cfg_addr == sbrp_pkg::OFS_DATA) && !busy_ff;
    assign wr_index  = cfg_wr_en && (cfg_addr == sbrp_pkg::OFS_INDEX) && !busy_ff;
    assign wr_target = cfg_wr_en && (cfg_addr == sbrp_pkg::OFS_TARGET) && !busy_ff;
    assign wr_ctrl   = cfg_wr_en && (cfg_addr == sbrp_pkg::OFS_CTRL);
    assign read_dir  = target_ff[sbrp_pkg::DIR_BIT];

    // Sequencer issues one bit command at a time
    always_comb begin
        nxt_st     = st_ff;
        nxt_step   = step_ff;
        nxt_data   = wr_data ? cfg_wdata : data_ff;
        nxt_index  = wr_index ? cfg_wdata : index_ff;
        nxt_target = wr_target ? cfg_wdata : target_ff;
        nxt_prot   = wr_ctrl ? cfg_wdata[sbrp_pkg::CTL_PROT_BIT] : prot_ff;
        nxt_fast   = wr_ctrl ? cfg_wdata[sbrp_pkg::CTL_FAST_BIT] : fast_ff;
        nxt_err    = (wr_ctrl && cfg_wdata[sbrp_pkg::CTL_ERR_BIT]) ? 1'b0 : err_ff;
        nxt_busy   = busy_ff;
        nxt_shift  = shift_ff;
        nxt_bit    = bit_ff;
        nxt_pend   = pend_ff;
        bit_bus.cmd_valid = 1'b0;
        bit_bus.cmd       = sbrp_pkg::SBRP_CMD_START;
        bit_bus.wbit      = 1'b1;
        case (st_ff)
            SBRP_S_IDLE: begin
                if (wr_target) begin
                    nxt_busy = 1'b1;
                    nxt_step = sbrp_pkg::SBRP_STEP_ADDR;
                    nxt_st   = SBRP_S_START;
                end
            end
            SBRP_S_START: begin
                bit_bus.cmd = sbrp_pkg::SBRP_CMD_START;
                if (bit_bus.done) begin
                    nxt_pend = 1'b0;
                    nxt_bit  = 4'h0;
                    nxt_st   = SBRP_S_SEND;
                    // Short forms carry the real direction in the first address byte
                    if (step_ff == sbrp_pkg::SBRP_STEP_RADDR) begin
                        nxt_shift = {target_ff[7:1], 1'b1};
                    end else begin
                        nxt_shift = {target_ff[7:1], prot_ff & read_dir};
                    end
                end else if (!pend_ff && bit_bus.ready) begin
                    bit_bus.cmd_valid = 1'b1;
                    nxt_pend          = 1'b1;
                end
            end
            SBRP_S_SEND: begin
                bit_bus.cmd  = (bit_ff == sbrp_pkg::BYTE_BITS) ? sbrp_pkg::SBRP_CMD_READ
                                                               : sbrp_pkg::SBRP_CMD_WRITE;
                bit_bus.wbit = shift_ff[7];
                if (bit_bus.done) begin
                    nxt_pend = 1'b0;
                    if (bit_ff != sbrp_pkg::BYTE_BITS) begin
                        nxt_shift = {shift_ff[6:0], 1'b0};
                        nxt_bit   = bit_ff + 4'h1;
                    end else if (bit_bus.rbit) begin
                        nxt_err = 1'b1;
                        nxt_st  = SBRP_S_STOP;
                    end else begin
                        nxt_bit = 4'h0;
                        case (step_ff)
                            sbrp_pkg::SBRP_STEP_ADDR: begin
                                if (prot_ff && read_dir) begin
                                    nxt_st = SBRP_S_RECV;
                                end else if (prot_ff) begin
                                    nxt_step  = sbrp_pkg::SBRP_STEP_DATA;
                                    nxt_shift = data_ff;
                                end else begin
                                    nxt_step  = sbrp_pkg::SBRP_STEP_INDEX;
                                    nxt_shift = index_ff;
                                end
                            end
                            sbrp_pkg::SBRP_STEP_INDEX: begin
                                if (read_dir) begin
                                    nxt_step = sbrp_pkg::SBRP_STEP_RADDR;
                                    nxt_st   = SBRP_S_START;
                                end else begin
                                    nxt_step  = sbrp_pkg::SBRP_STEP_DATA;
                                    nxt_shift = data_ff;
                                end
                            end
                            sbrp_pkg::SBRP_STEP_RADDR: nxt_st = SBRP_S_RECV;
                            default:                   nxt_st = SBRP_S_STOP;
                        endcase
                    end
                end else if (!pend_ff && bit_bus.ready) begin
                    bit_bus.cmd_valid = 1'b1;
                    nxt_pend          = 1'b1;
                end
            end
            SBRP_S_RECV: begin
                // Ninth bit is the not-acknowledge that ends the read
                bit_bus.cmd  = (bit_ff == sbrp_pkg::BYTE_BITS) ? sbrp_pkg::SBRP_CMD_WRITE
                                                               : sbrp_pkg::SBRP_CMD_READ;
                bit_bus.wbit = 1'b1;
                if (bit_bus.done) begin
                    nxt_pend = 1'b0;
                    if (bit_ff != sbrp_pkg::BYTE_BITS) begin
                        nxt_shift = {shift_ff[6:0], bit_bus.rbit};
                        nxt_bit   = bit_ff + 4'h1;
                    end else begin
                        nxt_data = shift_ff;
                        nxt_st   = SBRP_S_STOP;
                    end
                end else if (!pend_ff && bit_bus.ready) begin
                    bit_bus.cmd_valid = 1'b1;
                    nxt_pend          = 1'b1;
                end
            end
            SBRP_S_STOP: begin
                bit_bus.cmd = sbrp_pkg::SBRP_CMD_STOP;
                if (bit_bus.done) begin
                    nxt_pend = 1'b0;
                    nxt_busy = 1'b0;
                    nxt_st   = SBRP_S_IDLE;
                end else if (!pend_ff && bit_bus.ready) begin
                    bit_bus.cmd_valid = 1'b1;
                    nxt_pend          = 1'b1;
                end
            end
            default: nxt_st = SBRP_S_IDLE;
        endcase
        bit_bus.fast = fast_ff;
    end

    // Read mux registered so the read port comes from a flop
    always_comb begin
        case (cfg_addr)
            sbrp_pkg::OFS_DATA:   nxt_rdata = data_ff;
            sbrp_pkg::OFS_INDEX:  nxt_rdata = index_ff;
            sbrp_pkg::OFS_TARGET: nxt_rdata = target_ff;
            sbrp_pkg::OFS_CTRL: begin
                nxt_rdata = sbrp_pkg::RST_BYTE;
                nxt_rdata[sbrp_pkg::CTL_PROT_BIT] = prot_ff;
                nxt_rdata[sbrp_pkg::CTL_BUSY_BIT] = busy_ff;
                nxt_rdata[sbrp_pkg::CTL_FAST_BIT] = fast_ff;
                nxt_rdata[sbrp_pkg::CTL_ERR_BIT]  = err_ff;
            end
            default: nxt_rdata = sbrp_pkg::RST_BYTE;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    // Only the global reset clears the request registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff     <= SBRP_S_IDLE;
            step_ff   <= sbrp_pkg::SBRP_STEP_ADDR;
            data_ff   <= sbrp_pkg::RST_BYTE;
            index_ff  <= sbrp_pkg::RST_BYTE;
            target_ff <= sbrp_pkg::RST_BYTE;
            prot_ff   <= 1'b0;
            fast_ff   <= 1'b0;
            err_ff    <= 1'b0;
            busy_ff   <= 1'b0;
            shift_ff  <= sbrp_pkg::RST_BYTE;
            bit_ff    <= 4'h0;
            pend_ff   <= 1'b0;
            rdata_ff  <= sbrp_pkg::RST_BYTE;
        end else begin
            st_ff     <= nxt_st;
            step_ff   <= nxt_step;
            data_ff   <= nxt_data;
            index_ff  <= nxt_index;
            target_ff <= nxt_target;
            prot_ff   <= nxt_prot;
            fast_ff   <= nxt_fast;
            err_ff    <= nxt_err;
            busy_ff   <= nxt_busy;
            shift_ff  <= nxt_shift;
            bit_ff    <= nxt_bit;
            pend_ff   <= nxt_pend;
            rdata_ff  <= nxt_rdata;
        end
    end
endmodule
`default_nettype wire

// ===== sbrp_assertions.sv
/* Port checker for sbrp_top: register port and open-drain pins.
   Bound into every sbrp_top; quarter counts come from its parameters. */
`timescale 1ns/1ns
`default_nettype none
module sbrp_assertions #(
    parameter int QTR_CYC      = 2,
    parameter int QTR_FAST_CYC = 2
) (
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       cfg_wr_en,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    input wire logic       scl_i,
    input wire logic       scl_o,
    input wire logic       scl_oe,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe
);
    localparam int START_MAX = 2 * QTR_CYC + 4;
    logic [7:0] idle_ff;
    logic       quiet;
    // Released longer than any high phase: no transfer can be running
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            idle_ff <= 8'h00;
        end else if (scl_oe || sda_oe || !scl_i || !sda_i) begin
            idle_ff <= 8'h00;
        end else if (idle_ff != 8'hFF) begin
            idle_ff <= idle_ff + 8'h01;
        end
    end
    assign quiet = 32'(idle_ff) >= 4 * QTR_CYC + 4;
    default clocking dclk @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence quiet_wr(logic [7:0] a);
        cfg_wr_en && cfg_addr == a && quiet;
    endsequence
    property reg_back(logic [7:0] a);
        quiet_wr(a) ##1 cfg_addr == a |=> cfg_rdata == $past(cfg_wdata, 2);
    endproperty
    a_pins_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("pin output not low");
    a_unmapped_zero: assert property ((cfg_addr < 8'hB0 || cfg_addr > 8'hB3) |=> cfg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reset_clears: assert property ($rose(nrst) |-> cfg_rdata == 8'h00 && !scl_oe && !sda_oe)
        else $error("state not clear after reset");
    a_data_reg_back: assert property (reg_back(8'hB0))
        else $error("data register lost write");
    a_index_reg_back: assert property (reg_back(8'hB1))
        else $error("index register lost write");
    a_target_reg_back: assert property (reg_back(8'hB2))
        else $error("target register lost write");
    a_busy_raise: assert property (quiet_wr(8'hB2) ##2 cfg_addr == 8'hB3 |=> cfg_rdata[5])
        else $error("busy not set by request");
    a_start_soon: assert property (quiet_wr(8'hB2) |-> ##[1:START_MAX] scl_oe)
        else $error("request did not start bus");
    a_err_clear: assert property (quiet_wr(8'hB3) ##0 cfg_wdata[1] ##1 cfg_addr == 8'hB3 |=> !cfg_rdata[1])
        else $error("error flag not cleared");
endmodule
bind sbrp_top sbrp_assertions #(.QTR_CYC(QTR_CYC), .QTR_FAST_CYC(QTR_FAST_CYC)) u_chk (.core_clk(core_clk),
    .nrst(nrst), .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

// ===== sbrp_target_model.sv
/* Two-wire target model: 256-byte memory behind one byte pointer.
   Expects pulled-up line levels; may stretch the clock after each bit. */
`timescale 1ns/1ns
`default_nettype none
module sbrp_target_model #(
    parameter logic [6:0] TADDR = 7'h52
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic stretch,
    output logic     scl_pull,
    output logic     sda_pull
);
    logic [7:0] mem [256];
    logic [7:0] idx = 8'h00;
    logic [7:0] sh = 8'h00;
    logic [3:0] bitn = 4'h0;
    logic [1:0] byten = 2'h0;
    logic       act = 1'b0, rd = 1'b0, hit = 1'b0, last_ack = 1'b0;
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
        for (int i = 0; i < 256; i++) begin
            mem[i] = ~8'(i);
        end
    end
    always @(negedge sda) begin
        if (scl) begin
            {act, rd, bitn, byten} = {2'b10, 4'h9, 2'h0};
        end
    end
    always @(posedge sda) begin
        if (scl) begin
            act = 1'b0;
        end
    end
    always @(posedge scl) begin
        if (act) begin
            sh = bitn < 8 ? {sh[6:0], sda} : sh;
            last_ack = bitn == 8 ? sda : last_ack;
            // A not-acknowledge ends the read, so the line is free for the stop
            rd = rd && !(bitn == 8 && sda);
        end
    end
    always @(negedge scl) begin
        if (act) begin
            byten = byten + {1'b0, bitn == 8};
            bitn = bitn >= 8 ? 4'h0 : bitn + 4'h1;
            sda_pull = 1'b0;
            if (bitn == 8 && !rd) begin
                if (byten == 0) begin
                    hit = sh[7:1] == TADDR;
                    rd = sh[0] && hit;
                end else if (hit && byten == 1) begin
                    idx = sh;
                end else if (hit) begin
                    mem[idx] = sh;
                end
                sda_pull = hit;
            end else if (rd && bitn < 8) begin
                sda_pull = ~mem[idx][3'(7 - bitn)];
            end
            if (stretch) begin
                scl_pull = 1'b1;
                #200 scl_pull = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== serial_bus_byte_request_port_tb.sv
/* Testbench for sbrp_top against a two-wire target model on pulled-up lines.
   Short quarter counts keep each transfer under two thousand clocks. */
`timescale 1ns/1ns
`default_nettype none
module serial_bus_byte_request_port_tb;
    localparam logic [6:0] TADDR = 7'h52;
    logic       core_clk = 1'b0;
    logic       nrst = 1'b0;
    logic       cfg_wr_en = 1'b0;
    logic       stretch = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [7:0] cfg_wdata = 8'h00;
    logic [7:0] cfg_rdata;
    logic       scl_oe, sda_oe, m_scl, m_sda;
    wire logic  scl = ~(scl_oe | m_scl);
    wire logic  sda = ~(sda_oe | m_sda);
    int         n_fail = 0;
    int         num_checks = 0;
    sbrp_top #(.QTR_CYC(4), .QTR_FAST_CYC(2)) dut (.core_clk(core_clk), .nrst(nrst), .cfg_wr_en(cfg_wr_en),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .scl_i(scl), .scl_o(),
        .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
    sbrp_target_model #(.TADDR(TADDR)) tgt (.scl(scl), .sda(sda), .stretch(stretch), .scl_pull(m_scl),
        .sda_pull(m_sda));
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        {cfg_wr_en, cfg_addr, cfg_wdata} = {1'b1, a, d};
        @(negedge core_clk);
        cfg_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        cfg_addr = a;
        @(negedge core_clk);
        d = cfg_rdata;
    endtask
    task automatic req(input logic [7:0] ta);
        logic [7:0] d;
        wr(8'hB2, ta);
        rd(8'hB3, d);
        chk("busy", 8'h20, d & 8'h20);
        for (int i = 0; i < 4000 && d[5] !== 1'b0; i++) rd(8'hB3, d);
        chk("busy end", 8'h00, d & 8'h20);
        chk("stop seen", 8'h00, {7'h00, tgt.act});
        // Let the lines settle so the next request starts from idle
        repeat (20) @(negedge core_clk);
    endtask
    task automatic t_reset;
        logic [7:0] d;
        // Let the synchronised reset release so reads see real register contents
        repeat (3) @(negedge core_clk);
        for (int a = 'hB0; a <= 'hB3; a++) begin
            rd(8'(a), d);
            chk("reset value", 8'h00, d);
        end
        wr(8'hB5, 8'hFF);
        rd(8'hB5, d);
        chk("unmapped", 8'h00, d);
        $display("test reset done");
    endtask
    task automatic t_write;
        logic [7:0] d;
        wr(8'hB0, 8'hA5);
        wr(8'hB1, 8'h3C);
        req({TADDR, 1'b0});
        chk("written byte", 8'hA5, tgt.mem[8'h3C]);
        rd(8'hB2, d);
        chk("target reg", {TADDR, 1'b0}, d);
        $display("test write done");
    endtask
    task automatic t_read;
        logic [7:0] d;
        stretch = 1'b1;
        wr(8'hB0, 8'h00);
        wr(8'hB1, 8'h3C);
        req({TADDR, 1'b1});
        rd(8'hB0, d);
        chk("read byte", 8'hA5, d);
        chk("final nack", 8'h01, {7'h00, tgt.last_ack});
        stretch = 1'b0;
        wr(8'hB1, 8'h81);
        req({TADDR, 1'b1});
        rd(8'hB0, d);
        chk("read byte", tgt.mem[8'h81], d);
        $display("test read done");
    endtask
    task automatic t_short;
        logic [7:0] d;
        wr(8'hB3, 8'h84);
        wr(8'hB1, 8'h11);
        wr(8'hB0, 8'h81);
        req({TADDR, 1'b0});
        chk("short pointer", 8'h81, tgt.idx);
        req({TADDR, 1'b1});
        rd(8'hB0, d);
        chk("short read", tgt.mem[8'h81], d);
        wr(8'hB3, 8'h00);
        $display("test short done");
    endtask
    task automatic t_nack;
        logic [7:0] d;
        req({TADDR ^ 7'h01, 1'b0});
        rd(8'hB3, d);
        chk("error set", 8'h02, d);
        wr(8'hB3, 8'h02);
        rd(8'hB3, d);
        chk("error clear", 8'h00, d);
        $display("test nack done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        t_reset();
        t_write();
        t_read();
        t_short();
        t_nack();
        // Mid-run reset must clear registers that now hold data
        @(negedge core_clk);
        nrst = 1'b0;
        repeat (3) @(negedge core_clk);
        nrst = 1'b1;
        t_reset();
        finish_test();
    end
    initial begin
        #640000;
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
